//--- design/rotate_instruction_unit.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: Plain left rotate, bit7 wraps, N Z only.
// RULE2: Right rotate through carry, updates C N Z.
// RULE3: Destination bit picks accumulator or file register.
// RULE4: Access bit picks access bank or bank pointer.
// RULE5: Low address with extension uses indexed offset.
// RULE6: Left rotate through carry, updates C N Z.
// RULE7: One word, four quarter phases per instruction.
module rotate_instruction_unit (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [15:0] instr_data,
	input  wire logic        instr_valid,
	output logic             instr_ready,
	output logic             instr_done,
	output logic             instr_illegal,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata
);
	import rotate_unit_pkg::*;

	// Two-flop release of the asynchronous reset.
	logic rst_meta_r;
	logic rst_n_r;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// Byte-wide data space; the array is kept whole so every 12-bit address is real.
	logic [7:0] general_purpose_file [0:(1 << ADDR_W) - 1];

	phase_t            phase_r;
	logic [15:0]       instr_r;
	logic [ADDR_W-1:0] eff_addr_r;
	logic [7:0]        operand_r;
	logic [7:0]        result_r;
	logic [7:0]        status_nxt_r;
	logic [7:0]        working_accumulator;
	logic [7:0]        status_r;
	logic [7:0]        ctrl_r;
	logic [3:0]        bank_pointer_register;
	logic [ADDR_W-1:0] index_base_r;
	logic [ADDR_W-1:0] mem_ptr_r;

	wire [5:0] opc    = instr_r[OPC_MSB:OPC_LSB];
	wire       dst_f  = instr_r[DST_BIT];
	wire       acc_b  = instr_r[ACC_BIT];
	wire [7:0] f_addr = instr_r[7:0];

	// True for the three rotate opcodes this unit executes.
	function automatic logic is_rotate(input logic [5:0] op);
		is_rotate = (op == OP_ROT_LEFT_PLAIN) || (op == OP_ROT_RIGHT_CARRY) || (op == OP_ROT_LEFT_CARRY);
	endfunction : is_rotate

	// Resolves the operand address from the access bit, bank pointer and index base.
	function automatic logic [ADDR_W-1:0] resolve_addr(input logic a, input logic ext, input logic [7:0] f,
			input logic [3:0] bank, input logic [ADDR_W-1:0] base);
		if (a) begin
			resolve_addr = {bank, f}; // RULE4
		end else if (ext && (f <= INDEXED_LIMIT)) begin
			resolve_addr = base + {4'h0, f}; // RULE5
		end else if (f <= INDEXED_LIMIT) begin
			resolve_addr = {ACCESS_LOW_BANK, f}; // RULE4
		end else begin
			resolve_addr = {ACCESS_HI_BANK, f}; // RULE4
		end
	endfunction : resolve_addr

	// A new word is taken only between instructions, so phases never overlap.
	assign instr_ready = (phase_r == PH_IDLE);

	// Quarter phase sequencer: decode, read, process, write.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			phase_r <= PH_IDLE;
		end else begin
			case (phase_r)
				PH_IDLE: phase_r <= instr_valid ? PH_Q1 : PH_IDLE; // RULE7
				PH_Q1:   phase_r <= is_rotate(opc) ? PH_Q2 : PH_IDLE;
				PH_Q2:   phase_r <= PH_Q3; // RULE7
				PH_Q3:   phase_r <= PH_Q4; // RULE7
				PH_Q4:   phase_r <= PH_IDLE; // RULE7
				default: phase_r <= PH_IDLE;
			endcase
		end
	end

	// The single program word is captured as the instruction is accepted.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			instr_r <= 16'h0000;
		end else if (instr_ready && instr_valid) begin
			instr_r <= instr_data; // RULE7
		end
	end

	// Decode in Q1 fixes the address, so bus writes to pointers later in the cycle do not move it.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			eff_addr_r <= '0;
		end else if (phase_r == PH_Q1) begin
			eff_addr_r <= resolve_addr(acc_b, ctrl_r[CTRL_EXT], f_addr, bank_pointer_register, index_base_r);
		end
	end

	// Q2 reads the file operand.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			operand_r <= 8'h00;
		end else if (phase_r == PH_Q2) begin
			operand_r <= general_purpose_file[eff_addr_r]; // RULE7
		end
	end

	// Q3 forms the rotated value and the new flags.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			result_r     <= 8'h00;
			status_nxt_r <= STAT_RST;
		end else if (phase_r == PH_Q3) begin
			case (opc)
				OP_ROT_LEFT_PLAIN: begin
					result_r                 <= {operand_r[6:0], operand_r[7]}; // RULE1
					status_nxt_r             <= status_r;
					status_nxt_r[STAT_N]     <= operand_r[6]; // RULE1
					status_nxt_r[STAT_Z]     <= (operand_r == 8'h00); // RULE1
				end
				OP_ROT_RIGHT_CARRY: begin
					result_r                 <= {status_r[STAT_C], operand_r[7:1]}; // RULE2
					status_nxt_r             <= status_r;
					status_nxt_r[STAT_C]     <= operand_r[0]; // RULE2
					status_nxt_r[STAT_N]     <= status_r[STAT_C]; // RULE2
					status_nxt_r[STAT_Z]     <= ({status_r[STAT_C], operand_r[7:1]} == 8'h00); // RULE2
				end
				OP_ROT_LEFT_CARRY: begin
					result_r                 <= {operand_r[6:0], status_r[STAT_C]}; // RULE6
					status_nxt_r             <= status_r;
					status_nxt_r[STAT_C]     <= operand_r[7]; // RULE6
					status_nxt_r[STAT_N]     <= operand_r[6]; // RULE6
					status_nxt_r[STAT_Z]     <= ({operand_r[6:0], status_r[STAT_C]} == 8'h00); // RULE6
				end
				default: begin
					result_r     <= operand_r;
					status_nxt_r <= status_r;
				end
			endcase
		end
	end

	// Accumulator: Q4 with the destination bit low wins over a bus write in the same cycle.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			working_accumulator <= WACC_RST;
		end else if ((phase_r == PH_Q4) && !dst_f) begin
			working_accumulator <= result_r; // RULE3
		end else if (reg_wr && (reg_addr == REG_WACC)) begin
			working_accumulator <= reg_wdata;
		end
	end

	// Flags: the instruction update wins over a software write in the same cycle.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			status_r <= STAT_RST;
		end else if (phase_r == PH_Q4) begin
			status_r <= status_nxt_r; // RULE1 RULE2 RULE6
		end else if (reg_wr && (reg_addr == REG_STATUS)) begin
			status_r <= reg_wdata;
		end
	end

	// File writes: Q4 with destination bit high, or software loading while idle.
	always_ff @(posedge clk) begin
		if ((phase_r == PH_Q4) && dst_f) begin
			general_purpose_file[eff_addr_r] <= result_r; // RULE3
		end else if (reg_wr && (reg_addr == REG_MEM_DATA) && (phase_r == PH_IDLE)) begin
			general_purpose_file[mem_ptr_r] <= reg_wdata;
		end
	end

	// Software control registers and the auto-incrementing memory pointer.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r                <= CTRL_RST;
			bank_pointer_register <= 4'h0;
			index_base_r          <= '0;
			mem_ptr_r             <= '0;
		end else begin
			if (reg_wr && (reg_addr == REG_CTRL)) ctrl_r <= reg_wdata;
			if (reg_wr && (reg_addr == REG_BANK)) bank_pointer_register <= reg_wdata[3:0];
			if (reg_wr && (reg_addr == REG_INDEX_LO)) index_base_r[7:0] <= reg_wdata;
			if (reg_wr && (reg_addr == REG_INDEX_HI)) index_base_r[11:8] <= reg_wdata[3:0];
			if (reg_wr && (reg_addr == REG_MEM_LO)) begin
				mem_ptr_r[7:0] <= reg_wdata;
			end else if (reg_wr && (reg_addr == REG_MEM_HI)) begin
				mem_ptr_r[11:8] <= reg_wdata[3:0];
			end else if ((reg_wr || reg_rd) && (reg_addr == REG_MEM_DATA) && (phase_r == PH_IDLE)) begin
				mem_ptr_r <= mem_ptr_r + 12'h001;
			end
		end
	end

	// Read data stand in the cycle after the strobe only; unmapped offsets read zero.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CTRL:     reg_rdata <= ctrl_r;
				REG_BANK:     reg_rdata <= {4'h0, bank_pointer_register};
				REG_WACC:     reg_rdata <= working_accumulator;
				REG_STATUS:   reg_rdata <= status_r;
				REG_INDEX_LO: reg_rdata <= index_base_r[7:0];
				REG_INDEX_HI: reg_rdata <= {4'h0, index_base_r[11:8]};
				REG_MEM_LO:   reg_rdata <= mem_ptr_r[7:0];
				REG_MEM_HI:   reg_rdata <= {4'h0, mem_ptr_r[11:8]};
				REG_MEM_DATA: reg_rdata <= general_purpose_file[mem_ptr_r];
				REG_PHASE:    reg_rdata <= {5'h00, phase_r};
				default:      reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Completion and refusal pulses, each one cycle wide.
	always_ff @(posedge clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			instr_done    <= 1'b0;
			instr_illegal <= 1'b0;
		end else begin
			instr_done    <= (phase_r == PH_Q4); // RULE7
			instr_illegal <= (phase_r == PH_Q1) && !is_rotate(opc);
		end
	end

	// Checks kept beside the datapath.
	sequence seq_q2_to_q4;
		(phase_r == PH_Q2) ##1 (phase_r == PH_Q3) ##1 (phase_r == PH_Q4);
	endsequence

	sequence seq_accept;
		(phase_r == PH_IDLE) && instr_valid;
	endsequence

	AST_PHASE_WALK: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE7
		seq_accept ##1 ((phase_r == PH_Q1) && is_rotate(opc)) |=> seq_q2_to_q4 ##1 instr_done)
		else $error("Rotate did not finish in four quarter phases.");

	AST_LEFT_PLAIN: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE1
		(phase_r == PH_Q4) && (opc == OP_ROT_LEFT_PLAIN) |->
			(result_r == {operand_r[6:0], operand_r[7]}) && (status_nxt_r[STAT_C] == status_r[STAT_C]))
		else $error("Plain left rotate result or carry wrong.");

	AST_RIGHT_CARRY: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE2
		(phase_r == PH_Q4) && (opc == OP_ROT_RIGHT_CARRY) |=>
			(status_r[STAT_C] == $past(operand_r[0])) && ($past(result_r[7]) == $past(status_r[STAT_C])))
		else $error("Right rotate through carry wrong.");

	AST_LEFT_CARRY: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE6
		(phase_r == PH_Q4) && (opc == OP_ROT_LEFT_CARRY) |=>
			(status_r[STAT_C] == $past(operand_r[7])) && (status_r[STAT_Z] == ($past(result_r) == 8'h00)))
		else $error("Left rotate through carry wrong.");

	AST_DEST_ACC: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE3
		(phase_r == PH_Q4) && !dst_f |=> (working_accumulator == $past(result_r)))
		else $error("Accumulator not loaded with result.");

	AST_DEST_FILE: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE3
		(phase_r == PH_Q4) && dst_f && !(reg_wr && (reg_addr == REG_WACC)) |=> $stable(working_accumulator))
		else $error("Accumulator changed on file destination.");

	AST_BANKED: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE4
		(phase_r == PH_Q1) && acc_b |=> (eff_addr_r == {$past(bank_pointer_register), f_addr}))
		else $error("Banked address not from bank pointer.");

	AST_INDEXED: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE5
		(phase_r == PH_Q1) && !acc_b && ctrl_r[CTRL_EXT] && (f_addr <= INDEXED_LIMIT) |=>
			(eff_addr_r == $past(index_base_r) + {4'h0, f_addr}))
		else $error("Indexed offset address wrong.");

	// N and Z must follow the rotated byte; carry is covered by the check above.
	AST_LEFT_PLAIN_FLAGS: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE1
		(phase_r == PH_Q4) && (opc == OP_ROT_LEFT_PLAIN) |=>
			(status_r[STAT_N] == $past(result_r[7])) && (status_r[STAT_Z] == ($past(result_r) == 8'h00)))
		else $error("Plain left rotate flags wrong.");

	// The old carry lands in bit 7, so N must equal that bit of the result.
	AST_RIGHT_CARRY_FLAGS: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE2
		(phase_r == PH_Q4) && (opc == OP_ROT_RIGHT_CARRY) |=>
			(status_r[STAT_N] == $past(result_r[7])) && (status_r[STAT_Z] == ($past(result_r) == 8'h00)))
		else $error("Right rotate through carry flags wrong.");

	// The file copy is looked at one cycle later, before any software load can reach it.
	AST_DEST_FILE_WRITE: assert property (@(posedge clk) disable iff (!rst_n_r) // RULE3
		(phase_r == PH_Q4) && dst_f |=> (general_purpose_file[$past(eff_addr_r)] == $past(result_r)))
		else $error("File register not loaded with result.");

endmodule : rotate_instruction_unit

//--- design/rotate_unit_pkg.sv
package rotate_unit_pkg;

	// Upper six opcode bits of the supported rotate instructions.
	localparam logic [5:0] OP_ROT_LEFT_PLAIN  = 6'h11;
	localparam logic [5:0] OP_ROT_RIGHT_CARRY = 6'h0C;
	localparam logic [5:0] OP_ROT_LEFT_CARRY  = 6'h0D;

	// Instruction word fields.
	localparam int OPC_MSB = 15;
	localparam int OPC_LSB = 10;
	localparam int DST_BIT = 9;
	localparam int ACC_BIT = 8;

	// Addressing constants.
	localparam logic [7:0] INDEXED_LIMIT   = 8'h5F;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK  = 4'hF;
	localparam int         ADDR_W          = 12;

	// Status and control register bit positions, and status, accumulator and control reset values.
	localparam int         STAT_C      = 0;
	localparam int         STAT_Z      = 2;
	localparam int         STAT_N      = 4;
	localparam logic [7:0] STAT_RST    = 8'h00;
	localparam logic [7:0] WACC_RST    = 8'h00;
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam int         CTRL_EXT    = 0;

	// Register offsets on the plain register port.
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_BANK     = 4'h1;
	localparam logic [3:0] REG_WACC     = 4'h2;
	localparam logic [3:0] REG_STATUS   = 4'h3;
	localparam logic [3:0] REG_INDEX_LO = 4'h4;
	localparam logic [3:0] REG_INDEX_HI = 4'h5;
	localparam logic [3:0] REG_MEM_LO   = 4'h6;
	localparam logic [3:0] REG_MEM_HI   = 4'h7;
	localparam logic [3:0] REG_MEM_DATA = 4'h8;
	localparam logic [3:0] REG_PHASE    = 4'h9;

	// Quarter phases of one instruction cycle, Gray coded from PH_IDLE up to PH_Q4.
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_Q1   = 3'h1,
		PH_Q2   = 3'h3,
		PH_Q3   = 3'h2,
		PH_Q4   = 3'h6
	} phase_t;

endpackage : rotate_unit_pkg

//--- dv/rotate_instruction_unit_tb.sv
`timescale 1ns/1ps
module rotate_instruction_unit_tb;
	import rotate_unit_pkg::*;

	typedef struct packed {
		logic [15:0] ins;
		logic        ext;
		logic [11:0] base;
		logic [11:0] addr;
		logic        cin;
		logic [7:0]  val;
		logic [7:0]  res;
		logic [7:0]  st;
	} row_t;

	logic        clk         = 1'b0;
	logic        reset_n     = 1'b0;
	logic [15:0] instr_data  = 16'h0000;
	logic        instr_valid = 1'b0;
	logic        instr_ready;
	logic        instr_done;
	logic        instr_illegal;
	logic [3:0]  reg_addr    = 4'h0;
	logic [7:0]  reg_wdata   = 8'h00;
	logic        reg_wr      = 1'b0;
	logic        reg_rd      = 1'b0;
	logic [7:0]  reg_rdata;
	int          bad_count   = 0;
	int          check_count = 0;
	row_t        rows [8];
	logic [7:0]  got;
	int          nd;
	int          ni;

	// Free running clock, 25 ns period.
	always #12.5 clk = ~clk;

	rotate_instruction_unit i_dut (
		.clk           (clk),
		.reset_n       (reset_n),
		.instr_data    (instr_data),
		.instr_valid   (instr_valid),
		.instr_ready   (instr_ready),
		.instr_done    (instr_done),
		.instr_illegal (instr_illegal),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata)
	);

	task automatic results();
		if (bad_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	// Each bus task waits its own edge first, so strobes are never reassigned in one time step.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic mem_ptr(input logic [11:0] a);
		wr(REG_MEM_LO, a[7:0]);
		wr(REG_MEM_HI, {4'h0, a[11:8]});
	endtask : mem_ptr

	// Issues one word and records the cycle of the done and illegal pulses after acceptance.
	task automatic exec(input logic [15:0] ins, output int d, output int il);
		d  = 0;
		il = 0;
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_data  <= ins;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		chk({7'h0, instr_ready}, 8'h00);
		for (int i = 1; i <= 8; i++) begin
			@(posedge clk);
			#1;
			if (instr_done === 1'b1 && d == 0) d = i;
			if (instr_illegal === 1'b1 && il == 0) il = i;
		end
		if (d == 0 && il == 0) begin
			bad_count++;
			results();
		end
	endtask : exec

	initial begin
		rows[0] = '{{OP_ROT_LEFT_PLAIN, 2'b10, 8'h20}, 1'b0, 12'h000, 12'h020, 1'b1, 8'hAB, 8'h57, 8'h01};
		rows[1] = '{{OP_ROT_LEFT_CARRY, 2'b00, 8'h20}, 1'b0, 12'h000, 12'h020, 1'b0, 8'hE6, 8'hCC, 8'h11};
		rows[2] = '{{OP_ROT_RIGHT_CARRY, 2'b00, 8'h20}, 1'b0, 12'h000, 12'h020, 1'b0, 8'hE6, 8'h73, 8'h00};
		rows[3] = '{{OP_ROT_RIGHT_CARRY, 2'b11, 8'h40}, 1'b1, 12'h123, 12'h340, 1'b0, 8'h01, 8'h00, 8'h05};
		rows[4] = '{{OP_ROT_LEFT_PLAIN, 2'b10, 8'h80}, 1'b0, 12'h000, 12'hF80, 1'b0, 8'h80, 8'h01, 8'h00};
		rows[5] = '{{OP_ROT_LEFT_CARRY, 2'b10, 8'h10}, 1'b1, 12'h123, 12'h133, 1'b1, 8'h80, 8'h01, 8'h01};
		rows[6] = '{{OP_ROT_RIGHT_CARRY, 2'b10, 8'h60}, 1'b1, 12'h123, 12'hF60, 1'b1, 8'h80, 8'hC0, 8'h10};
		rows[7] = '{{OP_ROT_LEFT_PLAIN, 2'b00, 8'h5F}, 1'b1, 12'hFF0, 12'h04F, 1'b0, 8'hFF, 8'hFF, 8'h10};
		// Reset values, unmapped place and the one-cycle read answer.
		repeat (10) @(posedge clk);
		chk({7'h0, instr_ready}, 8'h01);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		wr(4'hF, 8'hFF);
		foreach (rows[k]) begin
			rd(k[3:0] == 4'h4 ? 4'hF : k[3:0] == 4'h1 ? REG_PHASE : k[3:0], got);
			chk(got, 8'h00);
		end
		@(posedge clk);
		#1;
		chk(reg_rdata, 8'h00);
		// Ordinary cases: the bank pointer is always 3, so an access-bank row must ignore it.
		foreach (rows[r]) begin
			wr(REG_CTRL, {7'h0, rows[r].ext});
			wr(REG_BANK, 8'h03);
			wr(REG_INDEX_LO, rows[r].base[7:0]);
			wr(REG_INDEX_HI, {4'h0, rows[r].base[11:8]});
			wr(REG_WACC, 8'h5A);
			wr(REG_STATUS, {7'h0, rows[r].cin});
			mem_ptr(rows[r].addr);
			wr(REG_MEM_DATA, rows[r].val);
			exec(rows[r].ins, nd, ni);
			chk(nd[7:0], 8'h04);
			rd(REG_WACC, got);
			chk(got, rows[r].ins[DST_BIT] ? 8'h5A : rows[r].res);
			mem_ptr(rows[r].addr);
			rd(REG_MEM_DATA, got);
			chk(got, rows[r].ins[DST_BIT] ? rows[r].res : rows[r].val);
			rd(REG_STATUS, got);
			chk(got, rows[r].st);
		end
		// A non-rotate word is refused and leaves the file untouched.
		exec({6'h10, 2'b10, 8'h20}, nd, ni);
		chk(ni[7:0], 8'h01);
		chk(nd[7:0], 8'h00);
		mem_ptr(12'h020);
		rd(REG_MEM_DATA, got);
		chk(got, 8'hE6);
		// Back to back with valid held: second accepted at the done cycle, carry chains through.
		wr(REG_CTRL, 8'h00);
		wr(REG_STATUS, 8'h00);
		mem_ptr(12'h020);
		wr(REG_MEM_DATA, 8'h03);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_data  <= {OP_ROT_RIGHT_CARRY, 2'b10, 8'h20};
		nd = 0;
		for (int i = 1; i <= 8 && nd == 0; i++) begin
			@(posedge clk);
			#1;
			if (instr_done === 1'b1) nd = i;
		end
		chk(nd[7:0], 8'h05);
		@(posedge clk);
		instr_valid <= 1'b0;
		nd = 0;
		for (int i = 1; i <= 8 && nd == 0; i++) begin
			@(posedge clk);
			#1;
			if (instr_done === 1'b1) nd = i;
		end
		chk(nd[7:0], 8'h04);
		mem_ptr(12'h020);
		rd(REG_MEM_DATA, got);
		chk(got, 8'h80);
		rd(REG_STATUS, got);
		chk(got, 8'h11);
		// Phase readback mid-instruction; a file load while busy is refused and leaves the pointer alone.
		mem_ptr(12'h340);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_data  <= {OP_ROT_LEFT_PLAIN, 2'b01, 8'h40};
		@(posedge clk);
		instr_valid <= 1'b0;
		reg_rd      <= 1'b1;
		reg_addr    <= REG_PHASE;
		@(posedge clk);
		reg_rd    <= 1'b0;
		reg_wr    <= 1'b1;
		reg_addr  <= REG_MEM_DATA;
		reg_wdata <= 8'h77;
		#1;
		chk(reg_rdata, {5'h00, PH_Q1});
		@(posedge clk);
		reg_wr <= 1'b0;
		nd = 0;
		for (int i = 1; i <= 8 && nd == 0; i++) begin
			@(posedge clk);
			#1;
			if (instr_done === 1'b1) nd = i;
		end
		chk(nd[7:0], 8'h02);
		rd(REG_MEM_LO, got);
		chk(got, 8'h40);
		rd(REG_MEM_DATA, got);
		chk(got, 8'h00);
		rd(REG_WACC, got);
		chk(got, 8'h00);
		rd(REG_STATUS, got);
		chk(got, 8'h05);
		// Read data must fall back to zero in the cycle after a non-zero answer.
		@(posedge clk);
		#1;
		chk(reg_rdata, 8'h00);
		results();
	end
endmodule : rotate_instruction_unit_tb
